// ### hdl/periph_io.sv
`timescale 1ns/1ps
`include "periph_io_defines.svh"

// How it works
// - separate 16-bit outgoing and incoming display data ports.
// - display master clear output follows one control register bit.
// - command strobe goes out, display answers on its own response line.
// - command starts a timer; no response in 200 ms sets the timeout flag.
// - time read raises request, waits for ready, captures 16-bit word.
// - altitude counter advances on altimeter clock edges while pulse is high.
// - pulse trailing edge loads holding register, sets ready, clears counter.
// - altitude capture runs by itself, no processor action needed.
// - validity input is the top bit of the altitude holding register.
// - 11-bit keypad output latch and 13-bit pushbutton input buffer.
// - 8-bit thumbwheel input buffer.
// - a control bit selects pushbutton or thumbwheel inputs for keypad reads.
// - processor enables one or all numerals; keypad lights their indicators.
// - enter and escape presses latch into condition flags.
// - timer counts are derived from the system clock period.
module periph_io #(
  parameter int TIMEOUT_CYCLES = `DISP_TO_CYC
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  input  wire logic        CE,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic      [15:0] DISP_TX_DATA,
  output logic             DISP_CMD,
  output logic             DISP_MCLR,
  input  wire logic [15:0] DISP_RX_DATA,
  input  wire logic        DISP_RESP,
  output logic             TIME_REQ,
  input  wire logic        TIME_RDY,
  input  wire logic [15:0] TIME_DATA,
  input  wire logic        ALT_CLK,
  input  wire logic        ALT_PULSE,
  input  wire logic        ALT_VALID,
  output logic      [10:0] KEY_OUT,
  input  wire logic [12:0] KEY_IN,
  input  wire logic [7:0]  THUMB_IN,
  output logic      [7:0]  CC_FLAGS
);

  localparam int TW  = $clog2(TIMEOUT_CYCLES + 1);
  localparam int SYW = 58;

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    merge = (old & ~lane_mask(be)) | (wd & lane_mask(be));
  endfunction

  // synchronised pins
  logic [SYW-1:0] sy_level;
  logic [SYW-1:0] sy_rise;
  logic [SYW-1:0] sy_fall;

  pin_sync #(
    .W (SYW)
  ) u_sync (
    .clk   (CLK_SYS),
    .rst_n (RSTN),
    .ce    (CE),
    .pin   ({DISP_RX_DATA, DISP_RESP, TIME_RDY, TIME_DATA,
             ALT_CLK, ALT_PULSE, ALT_VALID, KEY_IN, THUMB_IN}),
    .level (sy_level),
    .rise  (sy_rise),
    .fall  (sy_fall)
  );

  periph_io_pkg::word_t rx_s;
  periph_io_pkg::word_t time_s;
  logic [12:0]          key_s;
  logic [7:0]           thumb_s;
  logic                 resp_rise;
  logic                 rdy_s;
  logic                 altclk_rise;
  logic                 pulse_s;
  logic                 pulse_fall;
  logic                 valid_s;
  logic                 enter_rise;
  logic                 escape_rise;

  assign rx_s        = sy_level[57:42];
  assign resp_rise   = sy_rise[41];
  assign rdy_s       = sy_level[40];
  assign time_s      = sy_level[39:24];
  assign altclk_rise = sy_rise[23];
  assign pulse_s     = sy_level[22];
  assign pulse_fall  = sy_fall[22];
  assign valid_s     = sy_level[21];
  assign key_s       = sy_level[20:8];
  assign thumb_s     = sy_level[7:0];
  assign enter_rise  = sy_rise[8 + `KEY_ENTER_BIT];
  assign escape_rise = sy_rise[8 + `KEY_ESCAPE_BIT];

  // bus slave: one wait cycle, then the access is accepted
  logic        ack_q;
  logic        req;
  logic        acc;
  logic        wr_acc;
  logic        rd_acc;
  logic [31:0] wd_m;
  logic [31:0] rd_mux;

  assign req             = AVS_READ | AVS_WRITE;
  // a frozen clock enable keeps the master waiting instead of losing the access
  assign AVS_WAITREQUEST = req & ~(ack_q & CE);
  assign acc             = req & ack_q & CE;
  assign wr_acc          = acc & AVS_WRITE;
  assign rd_acc          = acc & AVS_READ;
  assign wd_m            = AVS_WRITEDATA & lane_mask(AVS_BYTEENABLE);

  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
      ack_q <= 1'b0;
    else if (CE)
      ack_q <= req & ~ack_q;
  end

  // control register
  logic [3:0]  ctrl_q;
  logic        wr_ctrl;
  logic        wr_tx;
  logic        wr_key;
  logic        wr_clr;
  logic        rd_alt;
  logic        rd_time;
  logic [31:0] ctrl_m, tx_m, key_m;

  assign ctrl_m  = merge({28'h0, ctrl_q}, AVS_WRITEDATA, AVS_BYTEENABLE);
  assign tx_m    = merge({16'h0, tx_q}, AVS_WRITEDATA, AVS_BYTEENABLE);
  assign key_m   = merge({21'h0, key_out_q}, AVS_WRITEDATA, AVS_BYTEENABLE);
  assign wr_ctrl = wr_acc && AVS_ADDRESS == `REG_CTRL;
  assign wr_tx   = wr_acc && AVS_ADDRESS == `REG_DISP_TX && AVS_BYTEENABLE[1:0] != 2'b00;
  assign wr_key  = wr_acc && AVS_ADDRESS == `REG_KEY_OUT;
  assign wr_clr  = wr_acc && AVS_ADDRESS == `REG_FLAG_CLR;
  assign rd_alt  = rd_acc && AVS_ADDRESS == `REG_ALT;
  assign rd_time = rd_acc && AVS_ADDRESS == `REG_TIME;

  // clear and request bits are write-one pulses, never stored
  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
      ctrl_q <= `CTRL_RESET;
    else if (CE && wr_ctrl)
    begin
      ctrl_q[`CTRL_MCLR]  <= ctrl_m[`CTRL_MCLR];
      ctrl_q[`CTRL_THUMB] <= ctrl_m[`CTRL_THUMB];
    end
  end

  assign DISP_MCLR = ctrl_q[`CTRL_MCLR];

  // display port
  periph_io_pkg::disp_state_e disp_q;
  periph_io_pkg::word_t       tx_q;
  periph_io_pkg::word_t       rx_q;
  logic [TW-1:0]              timer_q;
  logic                       timeout_q;
  logic                       resp_q;
  logic                       to_hit;

  assign to_hit = disp_q == periph_io_pkg::DISP_WAIT &&
                  timer_q == TW'(TIMEOUT_CYCLES - 1);

  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
      tx_q <= '0;
    else if (CE && wr_tx)
      tx_q <= tx_m[15:0];
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      disp_q  <= periph_io_pkg::DISP_IDLE;
      timer_q <= '0;
    end
    else if (CE)
    begin
      case (disp_q)
        periph_io_pkg::DISP_IDLE:
        begin
          timer_q <= '0;
          if (wr_tx)
            disp_q <= periph_io_pkg::DISP_WAIT;
        end
        periph_io_pkg::DISP_WAIT:
        begin
          timer_q <= timer_q + TW'(1);
          if (resp_rise || to_hit)
            disp_q <= periph_io_pkg::DISP_IDLE;
        end
        default:
          disp_q <= periph_io_pkg::DISP_IDLE;
      endcase
    end
  end

  // a response word is taken with its strobe; late responses are still captured
  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
      rx_q <= '0;
    else if (CE && resp_rise)
      rx_q <= rx_s;
  end

  // set wins over clear on every sticky flag
  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
      timeout_q <= 1'b0;
    else if (CE)
    begin
      if (to_hit)
        timeout_q <= 1'b1;
      else if (wr_tx || (wr_ctrl && wd_m[`CTRL_TO_CLR]))
        timeout_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
      resp_q <= 1'b0;
    else if (CE)
    begin
      if (resp_rise)
        resp_q <= 1'b1;
      else if (wr_tx || (wr_clr && wd_m[`ST_RESP]))
        resp_q <= 1'b0;
    end
  end

  assign DISP_TX_DATA = tx_q;
  assign DISP_CMD     = disp_q == periph_io_pkg::DISP_WAIT;

  // time code reader
  periph_io_pkg::time_state_e tstate_q;
  periph_io_pkg::word_t       time_q;
  logic                       time_rdy_q;

  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
      tstate_q <= periph_io_pkg::TIME_IDLE;
    else if (CE)
    begin
      case (tstate_q)
        periph_io_pkg::TIME_IDLE:
          if (wr_ctrl && wd_m[`CTRL_TIME_REQ])
            tstate_q <= periph_io_pkg::TIME_WAIT;
        periph_io_pkg::TIME_WAIT:
          if (rdy_s)
            tstate_q <= periph_io_pkg::TIME_IDLE;
        default:
          tstate_q <= periph_io_pkg::TIME_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
      time_q <= '0;
    else if (CE && tstate_q == periph_io_pkg::TIME_WAIT && rdy_s)
      time_q <= time_s;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
      time_rdy_q <= 1'b0;
    else if (CE)
    begin
      if (tstate_q == periph_io_pkg::TIME_WAIT && rdy_s)
        time_rdy_q <= 1'b1;
      else if (rd_time)
        time_rdy_q <= 1'b0;
    end
  end

  assign TIME_REQ = tstate_q == periph_io_pkg::TIME_WAIT;

  // altimeter: its clock is oversampled, so it must stay below a quarter of CLK_SYS
  logic [14:0]          alt_cnt_q;
  periph_io_pkg::word_t alt_hold_q;
  logic                 alt_rdy_q;

  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
      alt_cnt_q <= '0;
    else if (CE)
    begin
      if (pulse_fall)
        alt_cnt_q <= '0;
      else if (altclk_rise && pulse_s)
        alt_cnt_q <= alt_cnt_q + 15'h0001;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
      alt_hold_q <= '0;
    else if (CE && pulse_fall)
      alt_hold_q <= {valid_s, alt_cnt_q};
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
      alt_rdy_q <= 1'b0;
    else if (CE)
    begin
      if (pulse_fall)
        alt_rdy_q <= 1'b1;
      else if (rd_alt)
        alt_rdy_q <= 1'b0;
    end
  end

  // keypad
  logic [10:0] key_out_q;
  logic        enter_q;
  logic        escape_q;

  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
      key_out_q <= `KEY_OUT_RESET;
    else if (CE && wr_key)
      key_out_q <= key_m[10:0];
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      enter_q  <= 1'b0;
      escape_q <= 1'b0;
    end
    else if (CE)
    begin
      if (enter_rise)
        enter_q <= 1'b1;
      else if (wr_clr && wd_m[`ST_ENTER])
        enter_q <= 1'b0;
      if (escape_rise)
        escape_q <= 1'b1;
      else if (wr_clr && wd_m[`ST_ESCAPE])
        escape_q <= 1'b0;
    end
  end

  assign KEY_OUT = key_out_q;

  // status and condition flags
  logic [7:0] status;

  always_comb
  begin
    status                = 8'h00;
    status[`ST_BUSY]      = disp_q == periph_io_pkg::DISP_WAIT;
    status[`ST_TIMEOUT]   = timeout_q;
    status[`ST_RESP]      = resp_q;
    status[`ST_ALT_RDY]   = alt_rdy_q;
    status[`ST_TIME_RDY]  = time_rdy_q;
    status[`ST_ENTER]     = enter_q;
    status[`ST_ESCAPE]    = escape_q;
    status[`ST_TIME_BUSY] = tstate_q == periph_io_pkg::TIME_WAIT;
  end

  assign CC_FLAGS = status;

  // read mux; unmapped words read as zero
  always_comb
  begin
    case (AVS_ADDRESS)
      `REG_CTRL:    rd_mux = {28'h0, ctrl_q};
      `REG_DISP_TX: rd_mux = {16'h0, tx_q};
      `REG_DISP_RX: rd_mux = {16'h0, rx_q};
      `REG_STATUS:  rd_mux = {24'h0, status};
      `REG_TIME:    rd_mux = {16'h0, time_q};
      `REG_ALT:     rd_mux = {16'h0, alt_hold_q};
      `REG_KEY_OUT: rd_mux = {21'h0, key_out_q};
      `REG_KEY_IN:
        if (ctrl_q[`CTRL_THUMB])
          rd_mux = {24'h0, thumb_s};
        else
          rd_mux = {19'h0, key_s};
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
      AVS_READDATA <= 32'h0000_0000;
    else if (CE && AVS_READ && !ack_q)
      AVS_READDATA <= rd_mux;
  end

endmodule

// ### hdl/periph_io_defines.svh
`ifndef PERIPH_IO_DEFINES_SVH
`define PERIPH_IO_DEFINES_SVH

// register word indexes (byte address = 4 * index)
`define REG_CTRL      4'h0
`define REG_DISP_TX   4'h1
`define REG_DISP_RX   4'h2
`define REG_STATUS    4'h3
`define REG_TIME      4'h4
`define REG_ALT       4'h5
`define REG_KEY_OUT   4'h6
`define REG_KEY_IN    4'h7
`define REG_FLAG_CLR  4'h8

// control bits
`define CTRL_MCLR     0
`define CTRL_THUMB    1
`define CTRL_TO_CLR   2
`define CTRL_TIME_REQ 3

// status / condition flag bits
`define ST_BUSY       0
`define ST_TIMEOUT    1
`define ST_RESP       2
`define ST_ALT_RDY    3
`define ST_TIME_RDY   4
`define ST_ENTER      5
`define ST_ESCAPE     6
`define ST_TIME_BUSY  7

// pushbutton input positions
`define KEY_ENTER_BIT  10
`define KEY_ESCAPE_BIT 11

// reset values
`define CTRL_RESET    4'h0
`define KEY_OUT_RESET 11'h000

// response timeout
`define DISP_TO_MS    200
`define CLK_KHZ       200000
`define DISP_TO_CYC   (`DISP_TO_MS * `CLK_KHZ)

`endif

// ### hdl/periph_io_pkg.sv
package periph_io_pkg;

  typedef enum logic [0:0] {
    DISP_IDLE,
    DISP_WAIT
  } disp_state_e;

  typedef enum logic [0:0] {
    TIME_IDLE,
    TIME_WAIT
  } time_state_e;

  typedef logic [15:0] word_t;

endpackage

// ### hdl/pin_sync.sv
`timescale 1ns/1ps

// two-stage synchroniser with a third stage used only for edge detection
module pin_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end
    else if (ce)
    begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~prev_q;
  assign fall  = ~sync_q & prev_q;

endmodule

// ### verif/periph_io_chk.sv
`timescale 1ns/1ps
module periph_io_chk #(
  parameter int TIMEOUT_CYCLES = 50
) (
  input wire logic        CLK_SYS,
  input wire logic        RSTN,
  input wire logic [3:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0]  AVS_BYTEENABLE,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        DISP_CMD,
  input wire logic        DISP_MCLR,
  input wire logic        TIME_REQ,
  input wire logic        ALT_PULSE,
  input wire logic [12:0] KEY_IN,
  input wire logic [10:0] KEY_OUT,
  input wire logic [7:0]  CC_FLAGS
);
  logic [31:0] cmd_cnt_q;
  logic        wr_ok;
  logic        rd_ok;
  assign wr_ok = AVS_WRITE && !AVS_WAITREQUEST;
  assign rd_ok = AVS_READ && !AVS_WAITREQUEST;
  // length of the current command, to bound the timeout window
  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN || !DISP_CMD)
      cmd_cnt_q <= 32'h0;
    else
      cmd_cnt_q <= cmd_cnt_q + 32'h1;
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  property p_mclr;
    wr_ok && AVS_ADDRESS == 4'h0 && AVS_BYTEENABLE[0] |=> DISP_MCLR == $past(AVS_WRITEDATA[0]);
  endproperty
  a_mclr: assert property (p_mclr) else $error("master clear wrong");
  property p_cmd_start;
    wr_ok && AVS_ADDRESS == 4'h1 && (|AVS_BYTEENABLE) && !DISP_CMD |=> DISP_CMD[*2];
  endproperty
  a_cmd_start: assert property (p_cmd_start) else $error("command strobe missing");
  property p_cmd_end;
    $fell(DISP_CMD) |-> CC_FLAGS[1] || CC_FLAGS[2];
  endproperty
  a_cmd_end: assert property (p_cmd_end) else $error("strobe ended without cause");
  property p_to_max;
    cmd_cnt_q <= TIMEOUT_CYCLES + 2;
  endproperty
  a_to_max: assert property (p_to_max) else $error("command outlived timeout");
  property p_to_min;
    $rose(CC_FLAGS[1]) |-> cmd_cnt_q + 2 >= TIMEOUT_CYCLES;
  endproperty
  a_to_min: assert property (p_to_min) else $error("timeout too early");
  property p_to_hold;
    $fell(CC_FLAGS[1]) |-> $past(wr_ok);
  endproperty
  a_to_hold: assert property (p_to_hold) else $error("timeout dropped alone");
  property p_time_req;
    $rose(TIME_REQ) |-> $past(wr_ok && AVS_ADDRESS == 4'h0 && AVS_WRITEDATA[3]);
  endproperty
  a_time_req: assert property (p_time_req) else $error("time request unasked");
  property p_time_done;
    $fell(TIME_REQ) |-> CC_FLAGS[4];
  endproperty
  a_time_done: assert property (p_time_done) else $error("time ready not set");
  property p_alt_rdy;
    $rose(CC_FLAGS[3]) |-> !ALT_PULSE && !$past(ALT_PULSE);
  endproperty
  a_alt_rdy: assert property (p_alt_rdy) else $error("altitude ready before pulse end");
  property p_alt_clr;
    $fell(CC_FLAGS[3]) |-> $past(rd_ok && AVS_ADDRESS == 4'h5);
  endproperty
  a_alt_clr: assert property (p_alt_clr) else $error("altitude ready lost");
  property p_enter;
    $rose(CC_FLAGS[5]) |-> $past(KEY_IN[10], 3);
  endproperty
  a_enter: assert property (p_enter) else $error("enter flag unpressed");
  property p_key_out;
    $changed(KEY_OUT) |-> $past(wr_ok && AVS_ADDRESS == 4'h6);
  endproperty
  a_key_out: assert property (p_key_out) else $error("keypad latch changed");
  c_timeout: cover property ($rose(CC_FLAGS[1]));
  c_resp: cover property ($rose(CC_FLAGS[2]));
  c_alt: cover property ($rose(CC_FLAGS[3]));
endmodule

bind periph_io periph_io_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk (
  .CLK_SYS(CLK_SYS), .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .DISP_CMD(DISP_CMD), .DISP_MCLR(DISP_MCLR),
  .TIME_REQ(TIME_REQ), .ALT_PULSE(ALT_PULSE), .KEY_IN(KEY_IN), .KEY_OUT(KEY_OUT),
  .CC_FLAGS(CC_FLAGS));

// ### verif/far_side.sv
`timescale 1ns/1ps
module far_side #(
  parameter logic [15:0] TIME_WORD = 16'h5A3C
) (
  input  wire logic        clk,
  input  wire logic        mute,
  input  wire logic        disp_cmd,
  input  wire logic [15:0] disp_tx,
  input  wire logic        time_req,
  output logic             disp_resp,
  output logic      [15:0] disp_rx,
  output logic             time_rdy,
  output logic      [15:0] time_data,
  output logic             alt_clk,
  output logic             alt_pulse,
  output logic             alt_valid
);
  int dly_q;
  int tq;
  initial
  begin
    {disp_resp, time_rdy, alt_clk, alt_pulse, alt_valid} = 5'h00;
    {disp_rx, time_data} = 32'h0;
    dly_q = 0;
    tq = 0;
  end
  // display answers the inverted word; a released bus toggles so stale data never matches
  always @(posedge clk)
  begin
    dly_q <= (disp_cmd && !mute) ? ((dly_q < 6) ? dly_q + 1 : dly_q) : 0;
    disp_resp <= disp_cmd && !mute && dly_q >= 5;
    disp_rx <= (disp_cmd && !mute && dly_q >= 3) ? ~disp_tx : ~disp_rx;
  end
  always @(posedge clk)
  begin
    tq <= time_req ? tq + 1 : 0;
    time_data <= (time_req && tq >= 2) ? TIME_WORD : ~time_data;
    time_rdy <= time_req && tq >= 4;
  end
  // altimeter clock runs only inside the pulse frame, 8 system cycles a period
  task automatic alt_burst(input int n, input logic v);
    alt_valid <= v;
    repeat (n)
    begin
      alt_pulse <= 1'b1;
      repeat (4) @(posedge clk);
      alt_clk <= 1'b1;
      repeat (4) @(posedge clk);
      alt_clk <= 1'b0;
    end
    alt_pulse <= 1'b0;
  endtask
endmodule

// ### verif/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int          TO_CYC = 50;
  localparam logic [15:0] TIME_WORD = 16'h5A3C;
  logic        clk_sys, rstn, ce, avs_read, avs_write, avs_waitrequest, mute, w;
  logic        disp_cmd, disp_mclr, disp_resp, time_req, time_rdy;
  logic        alt_clk, alt_pulse, alt_valid;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [15:0] disp_tx_data, disp_rx_data, time_data;
  logic [10:0] key_out;
  logic [12:0] key_in;
  logic [7:0]  thumb_in, cc_flags;
  int          num_errors, checked, n;
  periph_io #(.TIMEOUT_CYCLES(TO_CYC)) dut (
    .CLK_SYS(clk_sys), .RSTN(rstn), .CE(ce), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .DISP_TX_DATA(disp_tx_data), .DISP_CMD(disp_cmd),
    .DISP_MCLR(disp_mclr), .DISP_RX_DATA(disp_rx_data), .DISP_RESP(disp_resp),
    .TIME_REQ(time_req), .TIME_RDY(time_rdy), .TIME_DATA(time_data), .ALT_CLK(alt_clk),
    .ALT_PULSE(alt_pulse), .ALT_VALID(alt_valid), .KEY_OUT(key_out), .KEY_IN(key_in),
    .THUMB_IN(thumb_in), .CC_FLAGS(cc_flags));
  far_side #(.TIME_WORD(TIME_WORD)) fs (
    .clk(clk_sys), .mute(mute), .disp_cmd(disp_cmd), .disp_tx(disp_tx_data),
    .time_req(time_req), .disp_resp(disp_resp), .disp_rx(disp_rx_data),
    .time_rdy(time_rdy), .time_data(time_data), .alt_clk(alt_clk),
    .alt_pulse(alt_pulse), .alt_valid(alt_valid));
  task close_out;
    if (num_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one access; the trailing edge lets its effects land before anyone looks
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    w = 1'b1;
    // waitrequest and read data are looked at mid-cycle, where they are settled
    while (w !== 1'b0)
    begin
      @(negedge clk_sys);
      w = avs_waitrequest;
      q = avs_readdata;
      n++;
      if (n > 100)
      begin
        num_errors++;
        close_out;
      end
      @(posedge clk_sys);
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  task wait_cc(input int b);
    n = 0;
    checked++;
    while (cc_flags[b] !== 1'b1)
    begin
      @(posedge clk_sys);
      n++;
      if (n > 3000)
      begin
        num_errors++;
        close_out;
      end
    end
  endtask
  task do_reset;
    rstn <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
  endtask
  task t_regs;
    bus(0, 4'h0, 0); cmp("ctrl", 32'h0, q);
    bus(0, 4'h6, 0); cmp("key_out", 32'h0, q);
    bus(0, 4'h3, 0); cmp("status", 32'h0, q);
    bus(1, 4'hF, 32'hFFFFFFFF);
    bus(0, 4'hF, 0); cmp("unmapped", 32'h0, q);
  endtask
  task t_mclr;
    bus(1, 4'h0, 32'h1); cmp("mclr", 32'h1, disp_mclr);
    bus(1, 4'h0, 32'h0); cmp("mclr", 32'h0, disp_mclr);
  endtask
  task t_disp_ok(input logic [15:0] tx);
    bus(1, 4'h1, {16'h0, tx});
    cmp("cmd", 32'h1, disp_cmd);
    cmp("timeout", 32'h0, cc_flags[1]);
    cmp("tx", {16'h0, tx}, disp_tx_data);
    wait_cc(2);
    bus(0, 4'h2, 0); cmp("rx", {16'h0, ~tx}, q);
    bus(0, 4'h3, 0); cmp("status", 32'h4, q & 32'h7);
    bus(1, 4'h8, 32'h4);
  endtask
  task t_disp_to;
    mute <= 1'b1;
    bus(1, 4'h1, 32'h0F0F);
    wait_cc(1);
    cmp("span", 32'h1, (n >= TO_CYC - 6) && (n <= TO_CYC + 2));
    cmp("cmd", 32'h0, disp_cmd);
    bus(1, 4'h0, 32'h4); cmp("timeout", 32'h0, cc_flags[1]);
    bus(1, 4'h1, 32'hF0F0);
    wait_cc(1);
    mute <= 1'b0;
  endtask
  task t_time;
    bus(1, 4'h0, 32'h8); cmp("time_req", 32'h1, time_req);
    wait_cc(4);
    cmp("time_req", 32'h0, time_req);
    bus(0, 4'h4, 0); cmp("time", {16'h0, TIME_WORD}, q);
    cmp("time_rdy", 32'h0, cc_flags[4]);
  endtask
  task t_alt(input logic [14:0] cnt, input logic v);
    fs.alt_burst(cnt, v);
    wait_cc(3);
    bus(0, 4'h5, 0); cmp("alt", {16'h0, v, cnt}, q);
    cmp("alt_rdy", 32'h0, cc_flags[3]);
  endtask
  task t_key;
    bus(1, 4'h6, 32'h3FF); cmp("key_out", 32'h3FF, key_out);
    bus(1, 4'h6, 32'h4); cmp("key_out", 32'h4, key_out);
    key_in <= 13'h0004;
    repeat (4) @(posedge clk_sys);
    bus(0, 4'h7, 0); cmp("buttons", 32'h4, q);
    bus(1, 4'h0, 32'h2);
    bus(0, 4'h7, 0); cmp("thumb", 32'hB7, q);
    key_in <= 13'h0400;
    wait_cc(5);
    key_in <= 13'h0800;
    wait_cc(6);
    key_in <= 13'h0000;
    repeat (4) @(posedge clk_sys);
    bus(1, 4'h8, 32'h60);
    bus(0, 4'h3, 0); cmp("key flags", 32'h0, q & 32'h60);
    ce <= 1'b0;
    key_in <= 13'h0400;
    repeat (6) @(posedge clk_sys);
    cmp("frozen", 32'h0, cc_flags[5]);
    ce <= 1'b1;
    wait_cc(5);
    key_in <= 13'h0000;
    repeat (4) @(posedge clk_sys);
    bus(1, 4'h8, 32'h20);
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial
  begin
    {rstn, avs_read, avs_write, mute} = 4'h0;
    ce = 1'b1;
    avs_byteenable = 4'hF;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    key_in = 13'h0000;
    thumb_in = 8'hB7;
    num_errors = 0;
    checked = 0;
    do_reset;
    t_regs;
    t_mclr;
    t_disp_ok(16'h3C5A);
    t_disp_to;
    t_disp_ok(16'h1234);
    t_time;
    t_alt(15'd37, 1'b1);
    t_alt(15'd5, 1'b0);
    t_key;
    do_reset;
    t_regs;
    close_out;
  end
endmodule
